/* verilog/ffr_map.vh */
// Constants for the fault flag register bank and its command frames.
`ifndef FFR_MAP_VH
`define FFR_MAP_VH
`define FFR_FRAME_BITS      32
`define FFR_ADDR_MSB        31
`define FFR_ADDR_LSB        25
`define FFR_WR_BIT          24
`define FFR_DATA_BITS       24
`define FFR_ADDR_SP_STATUS  7'h1e
`define FFR_ADDR_SG_STATUS  7'h1f
`define FFR_ADDR_FAULT      7'h21
`define FFR_ADDR_IRQ_REQ    7'h23
`define FFR_ADDR_SOFT_RST   7'h24
`define FFR_BIT_SUMMARY     23
`define FFR_BIT_INTFLAG     22
`define FFR_BIT_SPI_ERR     10
`define FFR_BIT_HASH        9
`define FFR_BIT_UV          7
`define FFR_BIT_OV          6
`define FFR_BIT_TWARN       5
`define FFR_BIT_OT          4
`define FFR_BIT_INTPIN_WAKE 3
`define FFR_BIT_WAKEPIN     2
`define FFR_BIT_SPI_WAKE    1
`define FFR_BIT_POR         0
`define FFR_FLAG_MASK       24'h0006ff
`define FFR_FAULT_RST       24'h000001
`define FFR_PULSE_US        100
`define FFR_CLK_MHZ         25
`define FFR_PULSE_CYCLES    (`FFR_PULSE_US * `FFR_CLK_MHZ)
`endif

/* verilog/ffr_pulse.v */
// Timed active-low interrupt pulse generator.
`timescale 1ns/100ps
`include "ffr_map.vh"
module ffr_pulse
#(
    parameter CYCLES = `FFR_PULSE_CYCLES
)
(
    input  wire ref_clk,
    input  wire reset,
    input  wire start,
    output reg  int_out_n,
    output reg  int_oe
);
    reg [15:0] count;

    // Restarting mid-pulse simply stretches it; the host sees one pulse.
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            count     <= 16'h0000;
            int_out_n <= 1'b1;
            int_oe    <= 1'b0;
        end
        else if (start)
        begin
            count     <= CYCLES[15:0] - 16'h0001;
            int_out_n <= 1'b0;
            int_oe    <= 1'b1;
        end
        else if (count != 16'h0000)
        begin
            count <= count - 16'h0001;
        end
        else
        begin
            int_out_n <= 1'b1;
            int_oe    <= 1'b0;
        end
    end
endmodule

/* verilog/ffr_top.v */
// Fault flag register bank with SPI slave, pulse request and soft reset.
`timescale 1ns/100ps
`include "ffr_map.vh"
// Behaviour
// - Frame: address bits 31-25, write flag bit 24, 24 data bits.
// - Interrupt flag sets on switch event; clears on read.
// - SPI error flag sets on bad frame; clears on read without new error.
// - Hash flag sets on mismatch; clears on read once mismatch gone.
// - Undervoltage flag latches; clears after recovery and a read.
// - Overvoltage flag latches; clears after recovery and a read.
// - Thermal warning and overtemperature latch; clear after cooling and read.
// - Interrupt pin wake flag sets on wake; clears on read.
// - Wake input falling edge sets flag; clears on read.
// - SPI wake flag sets when SPI wakes device; clears on read.
// - Power-on flag sets on low supply; clears on read.
// - Zero-data write to 0x23 gives a 100 us interrupt pulse.
// - Pulse reply echoes command; request never sets interrupt flag.
// - Pulse reply bit 23 summary, bit 22 interrupt flag.
// - Zero-data write to 0x24 resets shifter and flag bank like power-on; pulse generator keeps running.
// - After reset summary and interrupt flag both read high.
// - First frame returns ground status and clears interrupt flag.
// - Fault contents return in reply to the following frame.
// - Summary bit is the OR of all fault flags.
module ffr_top
#(
    parameter PULSE_CYCLES = `FFR_PULSE_CYCLES
)
(
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        spi_sclk,
    input  wire        spi_cs_n,
    input  wire        spi_mosi,
    output reg         spi_miso,
    input  wire [20:0] ground_switch_input,
    input  wire [11:0] programmable_switch_input,
    input  wire        switch_event,
    input  wire        spi_error_event,
    input  wire        hash_mismatch,
    input  wire        undervoltage_flag,
    input  wire        overvoltage_flag,
    input  wire        temp_warning,
    input  wire        overtemperature_flag,
    input  wire        low_power_mode,
    input  wire        int_pin_in,
    input  wire        wake_n,
    input  wire        battery_supply_por,
    output wire        int_out_n,
    output wire        int_oe
);
    // Two-stage synchronisers for every pin from outside the clock domain.
    // The serial link clock must stay at or below one eighth of ref_clk,
    // because every edge of it costs two cycles of synchroniser latency.
    reg [6:0] s1;
    reg [6:0] s2;
    reg       sclk_d;
    reg       wake_d;
    reg       intp_d;
    wire      sclk_s = s2[0];
    wire      cs_s   = s2[1];
    wire      mosi_s = s2[2];
    wire      wake_s = s2[3];
    wire      intp_s = s2[4];
    wire      lpm_s  = s2[5];
    wire      por_s  = s2[6];

    always @(posedge ref_clk)
    begin
        s1     <= {battery_supply_por, low_power_mode, int_pin_in,
                   wake_n, spi_mosi, spi_cs_n, spi_sclk};
        s2     <= s1;
    end

    // Edge history starts at the idle level of each pin, so the release
    // of reset can never be mistaken for an edge.
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            sclk_d <= 1'b0;
            wake_d <= 1'b1;
            intp_d <= 1'b1;
        end
        else
        begin
            sclk_d <= sclk_s;
            wake_d <= wake_s;
            intp_d <= intp_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    reg  cs_d;
    wire cs_end    = cs_s & ~cs_d;
    wire cs_start  = ~cs_s & cs_d;

    reg  [31:0] shift_in;
    reg  [31:0] shift_out;
    reg  [5:0]  bit_count;
    reg  [7:0]  next_head;
    reg  [23:0] next_reply;
    reg         int_flag;
    reg  [23:0] fault;
    reg         first_frame;
    reg         woke;
    reg         pulse_start;
    reg         soft_reset;
    wire        rst_all = reset | soft_reset;

    wire [6:0]  f_addr = shift_in[`FFR_ADDR_MSB:`FFR_ADDR_LSB];
    wire        f_wr   = shift_in[`FFR_WR_BIT];
    wire [23:0] f_data = shift_in[23:0];

    // Checks whether an address is one this bank answers to.
    function addr_ok;
        input [6:0] a;
        begin
            addr_ok = (a == `FFR_ADDR_SP_STATUS) | (a == `FFR_ADDR_SG_STATUS)
                    | (a == `FFR_ADDR_FAULT) | (a == `FFR_ADDR_IRQ_REQ)
                    | (a == `FFR_ADDR_SOFT_RST);
        end
    endfunction

    // Command byte echoed at the top of a reply: address and write flag.
    function [7:0] head_of;
        input [6:0] a;
        input       w;
        begin
            head_of = {a, w};
        end
    endfunction

    // True for a write of all-zero data to the wanted address.
    function zero_write;
        input [6:0]  want;
        input [6:0]  a;
        input        w;
        input [23:0] d;
        begin
            zero_write = (a == want) & w & (d == 24'h000000);
        end
    endfunction

    // Builds a reply word from the two top flags and a 22-bit body.
    function [23:0] reply_word;
        input        sum;
        input        flg;
        input [21:0] body;
        begin
            reply_word = {sum, flg, body};
        end
    endfunction

    wire frame_ok  = cs_end & (bit_count == 6'd32) & addr_ok(f_addr);
    wire frame_bad = cs_end & ~((bit_count == 6'd32) & addr_ok(f_addr));
    wire rd_fault  = frame_ok & ~f_wr & (f_addr == `FFR_ADDR_FAULT);
    wire rd_status = frame_ok & ~f_wr & ((f_addr == `FFR_ADDR_SP_STATUS)
                    | (f_addr == `FFR_ADDR_SG_STATUS));
    // Flags masked to their defined positions, unused bits forced low.
    wire [23:0] flags = fault & `FFR_FLAG_MASK;
    wire summary   = |flags;
    // first frame already shows flag
    // The first frame has reported the flag and clears it, so replies
    // built at its end show it low.
    wire int_shown = int_flag & ~first_frame;

    // Serial shifter: sample on rising sclk, launch on falling sclk.
    always @(posedge ref_clk)
    begin
        cs_d <= cs_s;
        if (rst_all)
        begin
            cs_d      <= 1'b1;
            shift_in  <= 32'h00000000;
            shift_out <= 32'h00000000;
            bit_count <= 6'd0;
            spi_miso  <= 1'b0;
        end
        else if (cs_start)
        begin
            // Bit 31 stands at once, so the host's first rising sclk
            // finds it; each falling sclk then brings the next bit.
            bit_count <= 6'd0;
            shift_out <= {next_head[6:0], next_reply, 1'b0};
            spi_miso  <= next_head[7];
        end
        else if (~cs_s)
        begin
            if (sclk_rise)
            begin
                shift_in <= {shift_in[30:0], mosi_s};
                if (bit_count != 6'd63)
                    bit_count <= bit_count + 6'd1;
            end
            if (sclk_fall)
            begin
                spi_miso  <= shift_out[31];
                shift_out <= {shift_out[30:0], 1'b0};
            end
        end
    end

    // Flag bank. Events are applied after the clear so a set always wins.
    always @(posedge ref_clk)
    begin
        pulse_start <= 1'b0;
        soft_reset  <= 1'b0;
        if (rst_all)
        begin
            // reset leaves summary and flag high
            int_flag      <= 1'b1;
            fault         <= `FFR_FAULT_RST;
            first_frame   <= 1'b1;
            woke          <= 1'b0;
            next_head     <= 8'h00;
            next_reply    <= 24'h000000;
        end
        else
        begin
            // clear on status or fault read
            if (rd_status | rd_fault | (first_frame & frame_ok))
                int_flag <= 1'b0;
            if (frame_ok)
                first_frame <= 1'b0;
            // first frame answers ground status
            // Tracked every cycle until a valid frame ends, so the word
            // shifted out in that frame is live whatever came before.
            if (first_frame & ~frame_ok)
            begin
                next_head  <= head_of(`FFR_ADDR_SG_STATUS, 1'b0);
                next_reply <= reply_word(summary, int_flag,
                                         {1'b0, ground_switch_input});
            end
            // fault contents in the next reply
            // Captured at the same edge as the clear, so the host sees
            // the flags as they stood before its read.
            else if (rd_fault)
            begin
                next_head  <= head_of(f_addr, f_wr);
                next_reply <= reply_word(summary, int_shown, flags[21:0]);
            end
            else if (frame_ok & f_addr == `FFR_ADDR_IRQ_REQ)
            begin
                next_head  <= head_of(f_addr, f_wr);
                next_reply <= reply_word(summary, int_shown, 22'h000000);
            end
            else if (frame_ok & f_addr == `FFR_ADDR_SP_STATUS)
            begin
                next_head  <= head_of(f_addr, f_wr);
                next_reply <= reply_word(summary, int_shown,
                                         {10'h000,
                                          programmable_switch_input});
            end
            // Every other valid frame answers with ground status.
            else if (frame_ok)
            begin
                next_head  <= head_of(`FFR_ADDR_SG_STATUS, 1'b0);
                next_reply <= reply_word(summary, int_shown,
                                         {1'b0, ground_switch_input});
            end
            // Level faults release only when gone; pulse faults simply clear.
            if (rd_fault)
            begin
                fault[`FFR_BIT_SPI_ERR] <= 1'b0;
                fault[`FFR_BIT_HASH] <= hash_mismatch;
                fault[`FFR_BIT_UV] <= undervoltage_flag;
                fault[`FFR_BIT_OV] <= overvoltage_flag;
                fault[`FFR_BIT_TWARN] <= temp_warning;
                fault[`FFR_BIT_OT] <= overtemperature_flag;
                fault[`FFR_BIT_INTPIN_WAKE] <= 1'b0;
                fault[`FFR_BIT_WAKEPIN] <= 1'b0;
                fault[`FFR_BIT_SPI_WAKE] <= 1'b0;
                fault[`FFR_BIT_POR] <= 1'b0;
            end
            if (switch_event)
                int_flag <= 1'b1;
            if (spi_error_event | frame_bad)
                fault[`FFR_BIT_SPI_ERR] <= 1'b1;
            if (hash_mismatch)
                fault[`FFR_BIT_HASH] <= 1'b1;
            if (undervoltage_flag)
                fault[`FFR_BIT_UV] <= 1'b1;
            if (overvoltage_flag)
                fault[`FFR_BIT_OV] <= 1'b1;
            if (temp_warning)
                fault[`FFR_BIT_TWARN] <= 1'b1;
            if (overtemperature_flag)
                fault[`FFR_BIT_OT] <= 1'b1;
            if (lpm_s & ~intp_s & intp_d)
                fault[`FFR_BIT_INTPIN_WAKE] <= 1'b1;
            if (~wake_s & wake_d)
                fault[`FFR_BIT_WAKEPIN] <= 1'b1;
            woke <= lpm_s & cs_start;
            if (woke)
                fault[`FFR_BIT_SPI_WAKE] <= 1'b1;
            if (por_s)
                fault[`FFR_BIT_POR] <= 1'b1;
            fault[23:11] <= 13'h0000;
            fault[8]     <= 1'b0;
            if (frame_ok & zero_write(`FFR_ADDR_IRQ_REQ, f_addr, f_wr,
                                      f_data))
                pulse_start <= 1'b1;
            if (frame_ok & zero_write(`FFR_ADDR_SOFT_RST, f_addr, f_wr,
                                      f_data))
                soft_reset <= 1'b1;
        end
    end

    ffr_pulse #(.CYCLES(PULSE_CYCLES)) u_pulse
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .start     (pulse_start),
        .int_out_n (int_out_n),
        .int_oe    (int_oe)
    );
endmodule

/* sim/ffr_props.sv */
// Checker for the interrupt pulse and serial reply timing.
`timescale 1ns/100ps
module ffr_props
#(
    parameter PULSE_CYCLES = 2500
)
(
    input wire ref_clk,
    input wire reset,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_miso,
    input wire int_out_n,
    input wire int_oe
);
    reg [15:0] low_cnt;
    reg [3:0]  idle_cnt;
    // Pulse length so far, and cycles since the last frame closed.
    always @(posedge ref_clk)
    begin
        low_cnt  <= (reset || int_out_n) ? 16'h0 : low_cnt + 16'h1;
        idle_cnt <= (reset || !spi_cs_n) ? 4'h0
                  : idle_cnt + {3'h0, idle_cnt != 4'hf};
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    AST_OE_IN_PULSE: assert property (!int_out_n |-> int_oe)
        else $error("enable low in pulse");
    AST_OE_IDLE: assert property (int_out_n |-> !int_oe)
        else $error("enable high when idle");
    AST_PULSE_LEN: assert property ($rose(int_out_n)
        |-> low_cnt == PULSE_CYCLES) else $error("pulse width");
    AST_PULSE_HOLD: assert property ($fell(int_out_n)
        |-> !int_out_n [*8]) else $error("pulse too short");
    AST_PULSE_GAP: assert property ($fell(int_out_n) |-> spi_cs_n)
        else $error("pulse inside frame");
    AST_PULSE_CAUSE: assert property ($fell(int_out_n)
        |-> idle_cnt <= 4'h8) else $error("pulse not after frame");
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        reset |=> int_out_n) else $error("pulse after reset");
    AST_MISO_HOLD: assert property ($fell(spi_sclk) && !spi_cs_n
        |-> $stable(spi_miso) && $past(spi_miso) == $past(spi_miso, 2))
        else $error("reply bit moved");
endmodule
bind ffr_top ffr_props #(.PULSE_CYCLES(PULSE_CYCLES)) props_u (
    .ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .int_out_n(int_out_n),
    .int_oe(int_oe));

/* sim/ffr_host.sv */
// Serial host model that sends command frames and collects replies.
`timescale 1ns/100ps
module ffr_host
(
    input  wire  ref_clk,
    input  wire  spi_miso,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi
);
    // Link idles with the clock low and the chip deselected.
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Four reference cycles a half period give a 320 ns link clock.
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask
    // address, write flag and data, most significant bit first
    task automatic xfer(input int nb, input logic [31:0] cmd,
                        output logic [31:0] rsp);
        rsp = 32'h0;
        spi_cs_n <= 1'b0;
        half();
        for (int i = nb - 1; i >= 0; i--)
        begin
            spi_mosi <= cmd[i];
            half();
            spi_sclk <= 1'b1;
            half();
            rsp = {rsp[30:0], spi_miso};
            spi_sclk <= 1'b0;
        end
        half();
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (12) @(posedge ref_clk);
    endtask
endmodule

/* sim/ffr_top_tb.sv */
// Self-checking bench for the fault flag register bank.
`timescale 1ns/100ps
`include "ffr_map.vh"
module ffr_top_tb;
    localparam PC = 20;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        sclk, cs_n, mosi, miso, int_out_n, int_oe;
    logic [20:0] sg = 21'h0;
    logic [11:0] sp = 12'h0;
    logic [4:0]  lvl = 5'h0;
    logic [2:0]  pin = 3'h0;
    logic        swe = 1'b0;
    logic        spe = 1'b0;
    logic        por = 1'b0;
    logic [31:0] rsp;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          lowc = 0;
    ffr_top #(.PULSE_CYCLES(PC)) dut_u (.ref_clk(ref_clk), .reset(reset),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .ground_switch_input(sg), .programmable_switch_input(sp),
        .switch_event(swe), .spi_error_event(spe), .hash_mismatch(lvl[4]),
        .undervoltage_flag(lvl[3]), .overvoltage_flag(lvl[2]),
        .temp_warning(lvl[1]), .overtemperature_flag(lvl[0]),
        .low_power_mode(pin[0]), .int_pin_in(~pin[1]), .wake_n(~pin[2]),
        .battery_supply_por(por), .int_out_n(int_out_n), .int_oe(int_oe));
    ffr_host host_u (.ref_clk(ref_clk), .spi_miso(miso), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi));
    // Free-running 25 MHz clock.
    always #20 ref_clk = ~ref_clk;
    // Watchdog and pulse width count; a hang ends the run as a mismatch.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (int_out_n === 1'b0)
            lowc <= lowc + 1;
        if (cyc == 40000)
        begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("mismatches %0d of %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, exp, msk, input string m);
        check_count++;
        if ((got & msk) !== (exp & msk))
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic fr(input logic [6:0] a, input logic w,
                      input logic [23:0] d);
        host_u.xfer(32, {a, w, d}, rsp);
    endtask
    // Fault contents come back with whichever frame follows the read.
    task automatic rdf(input logic [23:0] exp);
        fr(`FFR_ADDR_FAULT, 1'b0, 24'h0);
        fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
        chk(rsp[23:0], exp, 24'hbfffff, "fault word");
    endtask
    // Start-up reads: programmable status first, then fault, then clear.
    task automatic after_rst();
        fr(`FFR_ADDR_SP_STATUS, 1'b0, 24'h0);
        chk(rsp[23:0], {3'b110, sg}, 24'hffffff, "first reply");
        fr(`FFR_ADDR_FAULT, 1'b0, 24'h0);
        chk(rsp[23:0], {12'h800, sp}, 24'hffffff, "second reply");
        fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
        chk(rsp[23:0], 24'h800001, 24'hbfffff, "reset fault");
        fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
        chk(rsp[23:0], {3'b000, sg}, 24'hffffff, "cleared");
    endtask
    function automatic logic [23:0] lvb(input int k);
        return 24'h800000 | ((k == 4) ? 24'h200 : (24'h10 << k));
    endfunction
    // Main sequence.
    initial
    begin
        void'($urandom(32'h218cb31c));
        tick(2);
        reset <= 1'b0;
        sg <= 21'($urandom);
        sp <= 12'($urandom);
        tick(6);
        after_rst();
        for (int k = 0; k < 5; k++)
        begin
            lvl <= 5'h1 << k;
            rdf(lvb(k));
            lvl <= 5'h0;
            rdf(lvb(k));
            rdf(24'h0);
        end
        for (int k = 1; k < 3; k++)
        begin
            pin <= 3'h1 | (3'h1 << k);
            tick(4);
            pin <= 3'h1;
            tick(4);
            fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
            pin <= 3'h0;
            rdf(24'h800002 | (24'h8 >> (k - 1)));
            rdf(24'h0);
        end
        for (int k = 0; k < 3; k++)
        begin
            if (k == 0)
                host_u.xfer(31, 32'h0, rsp);
            else if (k == 1)
                fr(7'h05, 1'b0, 24'h0);
            else
            begin
                spe <= 1'b1;
                tick(1);
                spe <= 1'b0;
            end
            rdf(24'h800400);
        end
        rdf(24'h0);
        swe <= 1'b1;
        tick(1);
        swe <= 1'b0;
        rdf(24'h0);
        chk(rsp[23:0], 24'h400000, 24'h400000, "event flag");
        por <= 1'b1;
        tick(4);
        por <= 1'b0;
        tick(4);
        rdf(24'h800001);
        lowc = 0;
        fr(`FFR_ADDR_IRQ_REQ, 1'b1, 24'h0);
        tick(2 * PC);
        chk(24'(lowc), PC, 24'hffffff, "pulse width");
        fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
        chk(rsp[23:0], 24'h0, 24'hc00000, "request reply");
        chk({16'h0000, rsp[31:24]}, {16'h0000, `FFR_ADDR_IRQ_REQ, 1'b1},
            24'h0000ff, "request echo");
        lowc = 0;
        fr(`FFR_ADDR_IRQ_REQ, 1'b1, 24'($urandom) | 24'h1);
        tick(2 * PC);
        chk(24'(lowc), 24'h0, 24'hffffff, "refused request");
        fr(`FFR_ADDR_SOFT_RST, 1'b1, 24'($urandom) | 24'h100);
        fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
        fr(`FFR_ADDR_SG_STATUS, 1'b0, 24'h0);
        chk(rsp[23:0], {3'b000, sg}, 24'hffffff, "no reset");
        sg <= 21'($urandom);
        sp <= 12'($urandom);
        fr(`FFR_ADDR_SOFT_RST, 1'b1, 24'h0);
        after_rst();
        give_verdict();
    end
endmodule
